// ---- design/spsl_pkg.sv ----
// shared constants for the serial port select and logic output block
package spsl_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_TX_DATA = 8'h08;
    localparam logic [7:0] OFS_CONV_IN = 8'h0C;
    localparam logic [7:0] OFS_CONV_OUT = 8'h10;

    // decoded register index, SEL_NONE for an unmapped address
    localparam logic [2:0] SEL_CTRL = 3'h0;
    localparam logic [2:0] SEL_STATUS = 3'h1;
    localparam logic [2:0] SEL_TX_DATA = 3'h2;
    localparam logic [2:0] SEL_CONV_IN = 3'h3;
    localparam logic [2:0] SEL_CONV_OUT = 3'h4;
    localparam logic [2:0] SEL_NONE = 3'h7;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_OLS_BIT = 0;
    localparam int CTRL_GB_BIT = 1;
    localparam int CTRL_UNI_BIT = 2;
    localparam int CTRL_CFG_LO = 4;
    localparam int CTRL_SETUP_LO = 6;
    localparam logic [31:0] CTRL_MASK = 32'h0000_00F7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] TX_RESET = 32'h0000_0000;
    localparam int STAT_CMD_BIT = 0;
    localparam int STAT_RXV_BIT = 1;
    localparam int STAT_SEL_BIT = 2;
    localparam int STAT_BYTE_LO = 8;

    // ------------------------------------------------------------
    // serial port framing
    // ------------------------------------------------------------
    localparam int TX_W = 32;
    localparam int BYTE_W = 8;
    localparam logic [7:0] SYNC_ONES = 8'hFF;
    localparam logic [7:0] SYNC_FINAL = 8'hFE;
    localparam logic [3:0] SYNC_COUNT = 4'hF;

    // axi4-lite response codes
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- design/spsl_sync2.sv ----
// two flip-flop synchroniser for pins from outside the aclk domain
module spsl_sync2 #(
    parameter int W = 1
) (
    input wire logic aclk,            // system clock
    input wire logic aresetn,         // synchronous reset, active low
    input wire logic [W-1:0] din,     // asynchronous pin levels
    output logic [W-1:0] dout         // levels after two flops
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] dout_reg;

    // first stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '1;
            dout_reg <= '1;
        end else begin
            meta_reg <= din;
            dout_reg <= meta_reg;
        end
    end

    assign dout = dout_reg;
endmodule // spsl_sync2

// ---- design/spsl_sync_detect.sv ----
// detector for the serial port initialisation byte sequence
module spsl_sync_detect import spsl_pkg::*; (
    input wire logic aclk,            // system clock
    input wire logic aresetn,         // synchronous reset, active low
    input wire logic byte_valid,      // one-cycle pulse, byte complete
    input wire logic [7:0] byte_data, // received byte
    output logic cmd_pulse            // one-cycle pulse, command mode entered
);
    logic [3:0] ones_cnt_reg;
    logic cmd_pulse_reg;

    // count all-ones bytes, saturating; any other byte restarts the count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ones_cnt_reg <= 4'h0;
            cmd_pulse_reg <= 1'b0;
        end else begin
            cmd_pulse_reg <= 1'b0;
            if (byte_valid) begin
                if (byte_data == SYNC_ONES) begin
                    if (ones_cnt_reg != SYNC_COUNT) begin
                        ones_cnt_reg <= ones_cnt_reg + 4'h1;
                    end
                end else if (byte_data == SYNC_FINAL && ones_cnt_reg == SYNC_COUNT) begin
                    cmd_pulse_reg <= 1'b1;
                    ones_cnt_reg <= 4'h0;
                end else begin
                    ones_cnt_reg <= 4'h0;
                end
            end
        end
    end

    assign cmd_pulse = cmd_pulse_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_SYNC_ENTER: assert property (@(posedge aclk) disable iff (!aresetn)
        byte_valid && byte_data == SYNC_FINAL && ones_cnt_reg == SYNC_COUNT |=> cmd_pulse)
        else $error("command mode not entered after sync sequence");
    AST_SYNC_SHORT: assert property (@(posedge aclk) disable iff (!aresetn)
        !(byte_valid && ones_cnt_reg == SYNC_COUNT) |=> !cmd_pulse)
        else $error("command mode entered without full sync run");
endmodule // spsl_sync_detect

// ---- design/spsl_top.sv ----
// serial port select gating, shift logic, logic outputs and axi4-lite registers
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
module spsl_top import spsl_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int CONV_W = 24
) (
    input wire logic aclk,                  // system clock, 250 MHz
    input wire logic aresetn,               // synchronous reset, active low
    input wire logic [ADDR_W-1:0] awaddr,   // write address
    input wire logic awvalid,               // write address valid
    output logic awready,                   // write address ready
    input wire logic [31:0] wdata,          // write data
    input wire logic [3:0] wstrb,           // write byte enables
    input wire logic wvalid,                // write data valid
    output logic wready,                    // write data ready
    output logic [1:0] bresp,               // write response
    output logic bvalid,                    // write response valid
    input wire logic bready,                // write response ready
    input wire logic [ADDR_W-1:0] araddr,   // read address
    input wire logic arvalid,               // read address valid
    output logic arready,                   // read address ready
    output logic [31:0] rdata,              // read data
    output logic [1:0] rresp,               // read response
    output logic rvalid,                    // read data valid
    input wire logic rready,                // read data ready
    input wire logic select_n,              // port select pin, active low
    input wire logic serial_clk,            // serial clock pin from host
    input wire logic serial_data_in,        // serial data pin from host
    output logic serial_data_out,           // serial data pin level
    output logic serial_data_out_oe,        // high while data pin driven
    output logic logic_out_low_or_guard,    // first logic output, 1 = positive rail
    output logic logic_out_high,            // second logic output, 1 = positive rail
    output logic guard_drive_en             // first output acts as guard drive
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 8 || ADDR_W > 32 || CONV_W < 2 || CONV_W > 32) begin : g_bad_param
        $error("spsl_top: ADDR_W must be 8..32 and CONV_W 2..32");
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // map an address to a register index; unaligned or high bits miss
    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [2:0] s;
        s = SEL_NONE;
        if ((a >> 8) == '0) begin
            unique case (a[7:0])
                OFS_CTRL: s = SEL_CTRL;
                OFS_STATUS: s = SEL_STATUS;
                OFS_TX_DATA: s = SEL_TX_DATA;
                OFS_CONV_IN: s = SEL_CONV_IN;
                OFS_CONV_OUT: s = SEL_CONV_OUT;
                default: s = SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // apply byte enables to a stored word
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic aw_full_reg, w_full_reg, bvalid_reg, awready_reg, wready_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg;
    logic arready_reg, rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic do_write;
    logic [2:0] wsel;
    logic [31:0] ctrl_reg, tx_data_reg, rd_word;
    logic [CONV_W-1:0] conv_in_reg, conv_code;
    logic cmd_mode_reg, rx_valid_reg;
    logic csn_s, sclk_s, sdi_s, sclk_d_reg, csn_d_reg;
    logic sclk_rise, sclk_fall, sel_start;
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_shift_reg, rx_byte_reg;
    logic byte_done_reg, cmd_pulse;
    logic [TX_W-1:0] tx_shift_reg;
    logic sdo_reg, sdo_oe_reg, lo_reg, hi_reg, guard_reg;
    logic [1:0] pair_sel;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign wsel = reg_sel(aw_addr_reg);

    // address and data are held independently; readies return once the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            if (awvalid && awready_reg) begin
                aw_addr_reg <= awaddr;
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (wvalid && wready_reg) begin
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
                w_full_reg <= 1'b1;
                wready_reg <= 1'b0;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (wsel == SEL_NONE || wsel == SEL_CONV_OUT) ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // control, transmit word and converter input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= CTRL_RESET;
            tx_data_reg <= TX_RESET;
            conv_in_reg <= '0;
        end else if (do_write) begin
            if (wsel == SEL_CTRL) begin
                ctrl_reg <= wmerge(ctrl_reg, w_data_reg, w_strb_reg) & CTRL_MASK;
            end
            if (wsel == SEL_TX_DATA) begin
                tx_data_reg <= wmerge(tx_data_reg, w_data_reg, w_strb_reg);
            end
            if (wsel == SEL_CONV_IN) begin
                conv_in_reg <= CONV_W'(wmerge(32'(conv_in_reg), w_data_reg, w_strb_reg));
            end
        end
    end

    // sticky status flags: write one clears, a same-cycle set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_mode_reg <= 1'b0;
            rx_valid_reg <= 1'b0;
        end else begin
            if (do_write && wsel == SEL_STATUS && w_strb_reg[0]) begin
                if (w_data_reg[STAT_CMD_BIT]) begin
                    cmd_mode_reg <= 1'b0;
                end
                if (w_data_reg[STAT_RXV_BIT]) begin
                    rx_valid_reg <= 1'b0;
                end
            end
            if (cmd_pulse) begin
                cmd_mode_reg <= 1'b1;
            end
            if (byte_done_reg) begin
                rx_valid_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // result coding
    // ------------------------------------------------------------
    // conv_in is offset binary; bipolar flips the msb into two's complement
    always_comb begin
        conv_code = conv_in_reg;
        if (!ctrl_reg[CTRL_UNI_BIT]) begin
            conv_code[CONV_W-1] = ~conv_in_reg[CONV_W-1];
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    // read data mux, unused upper bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (reg_sel(araddr))
            SEL_CTRL: rd_word = ctrl_reg;
            SEL_STATUS: begin
                rd_word[STAT_CMD_BIT] = cmd_mode_reg;
                rd_word[STAT_RXV_BIT] = rx_valid_reg;
                rd_word[STAT_SEL_BIT] = ~csn_s;
                rd_word[STAT_BYTE_LO +: BYTE_W] = rx_byte_reg;
            end
            SEL_TX_DATA: rd_word = tx_data_reg;
            SEL_CONV_IN: rd_word = 32'(conv_in_reg);
            SEL_CONV_OUT: rd_word = 32'(conv_code);
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // one read at a time, answered the cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else begin
            if (arvalid && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= (reg_sel(araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            if (rvalid_reg && rready) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // serial pin sampling
    // ------------------------------------------------------------
    spsl_sync2 #(.W(3)) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({select_n, serial_clk, serial_data_in}),
        .dout({csn_s, sclk_s, sdi_s})
    );

    // previous levels for edge finding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_d_reg <= 1'b0;
            csn_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            csn_d_reg <= csn_s;
        end
    end

    // a host that drops select with the clock high would fake an edge; it must not
    assign sclk_rise = sclk_s & ~sclk_d_reg & ~csn_s;
    assign sclk_fall = ~sclk_s & sclk_d_reg & ~csn_s;
    assign sel_start = ~csn_s & csn_d_reg;

    // ------------------------------------------------------------
    // receive shifter
    // ------------------------------------------------------------
    // sample on rising clock, msb first; a frame end drops a partial byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_cnt_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_byte_reg <= 8'h00;
            byte_done_reg <= 1'b0;
        end else begin
            byte_done_reg <= 1'b0;
            if (csn_s) begin
                bit_cnt_reg <= 3'h0;
            end else if (sclk_rise) begin
                rx_shift_reg <= {rx_shift_reg[6:0], sdi_s};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    rx_byte_reg <= {rx_shift_reg[6:0], sdi_s};
                    byte_done_reg <= 1'b1;
                end
            end
        end
    end

    spsl_sync_detect u_sync_detect (
        .aclk(aclk),
        .aresetn(aresetn),
        .byte_valid(byte_done_reg),
        .byte_data(rx_byte_reg),
        .cmd_pulse(cmd_pulse)
    );

    // ------------------------------------------------------------
    // transmit shifter
    // ------------------------------------------------------------
    // word loads at select fall and shifts on falling clock; past 32 bits zeros follow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_shift_reg <= '0;
            sdo_reg <= 1'b0;
        end else if (sel_start) begin
            tx_shift_reg <= tx_data_reg;
            sdo_reg <= tx_data_reg[TX_W-1];
        end else if (sclk_fall) begin
            tx_shift_reg <= {tx_shift_reg[TX_W-2:0], 1'b0};
            sdo_reg <= tx_shift_reg[TX_W-2];
        end
    end

    // data pin driven while select is low, one cycle behind the synchronised select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdo_oe_reg <= 1'b0;
        end else begin
            sdo_oe_reg <= ~csn_s;
        end
    end

    // ------------------------------------------------------------
    // logic outputs
    // ------------------------------------------------------------
    assign pair_sel = ctrl_reg[CTRL_OLS_BIT] ? ctrl_reg[CTRL_CFG_LO +: 2] : ctrl_reg[CTRL_SETUP_LO +: 2];

    // a 1 drives the positive rail; guard mode forces the first output to 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lo_reg <= 1'b0;
            hi_reg <= 1'b0;
            guard_reg <= 1'b0;
        end else begin
            hi_reg <= pair_sel[1];
            guard_reg <= ctrl_reg[CTRL_GB_BIT];
            lo_reg <= ctrl_reg[CTRL_GB_BIT] ? 1'b0 : pair_sel[0];
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign serial_data_out = sdo_reg;
    assign serial_data_out_oe = sdo_oe_reg;
    assign logic_out_low_or_guard = lo_reg;
    assign logic_out_high = hi_reg;
    assign guard_drive_en = guard_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_IGNORE_CLK: assert property (csn_s |=> $stable(rx_shift_reg) && bit_cnt_reg == 3'h0)
        else $error("serial clock acted while deselected");
    AST_SDO_HIZ: assert property (csn_s ##1 csn_s |-> !serial_data_out_oe)
        else $error("data output driven while deselected");
    AST_SDO_DRIVE: assert property (!csn_s ##1 !csn_s |-> serial_data_out_oe)
        else $error("data output not driven while selected");
    AST_RX_BIT: assert property (sclk_rise |=> rx_shift_reg[0] == $past(sdi_s))
        else $error("input bit not shifted on rising clock");
    AST_TX_BIT: assert property (sclk_fall && !sel_start |=> serial_data_out == $past(tx_shift_reg[TX_W-2]))
        else $error("output bit not advanced on falling clock");
    AST_OUT_SRC: assert property ($stable(ctrl_reg) [*2] |-> logic_out_high ==
        (ctrl_reg[CTRL_OLS_BIT] ? ctrl_reg[CTRL_CFG_LO + 1] : ctrl_reg[CTRL_SETUP_LO + 1]))
        else $error("logic output source wrong");
    AST_RAIL: assert property (!ctrl_reg[CTRL_GB_BIT] && pair_sel[0] |=> logic_out_low_or_guard)
        else $error("logic one not at positive rail");
    AST_GUARD: assert property (ctrl_reg[CTRL_GB_BIT] |=> guard_drive_en && !logic_out_low_or_guard)
        else $error("guard enable did not take the first output");
    AST_UNIPOLAR: assert property (ctrl_reg[CTRL_UNI_BIT] |-> conv_code == conv_in_reg)
        else $error("unipolar code altered");
    AST_MIDSCALE: assert property (!ctrl_reg[CTRL_UNI_BIT] && conv_in_reg == {1'b0, {(CONV_W-1){1'b1}}}
        |-> conv_code == {CONV_W{1'b1}})
        else $error("bipolar mid-scale code wrong");
endmodule // spsl_top

// ---- tb/spsl_host.sv ----
// host-side serial master model for the select, clock and data pins
module spsl_host (
    output logic select_n, // port select, active low
    output logic serial_clk, // still outside frames except when stray pulses it
    output logic serial_data_in, // data towards the device
    input wire logic serial_data_out, // data from the device
    input wire logic serial_data_out_oe // device drives data pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: deselected, clock low
    initial begin
        select_n = 1'b1;
        serial_clk = 1'b0;
        serial_data_in = 1'b1;
    end
    // one byte msb first; select moves only while the clock is low
    // the 0.3 ns offset keeps every pin change off an aclk edge; the frame still lasts 1125 ns
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic oe_seen);
        oe_seen = 1'b1;
        #0.3 select_n = 1'b0;
        for (int k = 7; k >= 0; k--) begin
            serial_data_in = tx[k];
            #62.5 serial_clk = 1'b1;
            rx[k] = serial_data_out;
            oe_seen = oe_seen & serial_data_out_oe;
            #62.5 serial_clk = 1'b0;
        end
        #62.5 select_n = 1'b1;
        serial_data_in = ~serial_data_in; // a released line keeps no stale level
        #62.2;
    endtask
    // clock pulses with select high, only when a test asks for them
    task automatic stray(input int n);
        #0.3;
        repeat (n) begin
            #62.5 serial_clk = 1'b1;
            #62.5 serial_clk = 1'b0;
        end
        #61.7;
    endtask
endmodule // spsl_host

// ---- tb/test_spsl_top.sv ----
// self-checking bench for the serial port select and logic output block
module test_spsl_top import spsl_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic select_n, serial_clk, serial_data_in, serial_data_out, serial_data_out_oe;
    logic logic_out_low_or_guard, logic_out_high, guard_drive_en, ok;
    logic [7:0] awaddr, araddr, rx, c;
    logic [31:0] wdata, rdata, v, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [7:0] ctab [8] = '{8'h21, 8'h11, 8'h80, 8'h40, 8'h13, 8'hC0, 8'h70, 8'hB1};
    int num_errors = 0;
    int n_compared = 0;
    spsl_top #(.ADDR_W(8), .CONV_W(24)) spsl_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .select_n, .serial_clk, .serial_data_in, .serial_data_out, .serial_data_out_oe,
        .logic_out_low_or_guard, .logic_out_high, .guard_drive_en);
    spsl_host spsl_host_inst (.select_n, .serial_clk, .serial_data_in, .serial_data_out, .serial_data_out_oe);
    // ------------------------------------------------------------
    // clock, checks and bus tasks
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compared=%0d mismatches=%0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // a wait that ran out counts as a mismatch and ends the run
    task automatic tmo(input int k);
        if (k >= 64) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] dw);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= dw;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        r = bresp;
        tmo(k);
    endtask
    task automatic axr(input logic [7:0] a);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        v = rdata;
        r = rresp;
        tmo(k);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        axr(OFS_CTRL);
        chk(v, CTRL_RESET);
        axr(8'h14);
        chk(32'(r), 32'(RESP_SLVERR));
        axw(OFS_CONV_OUT, 32'h0000_0001);
        chk(32'(r), 32'(RESP_SLVERR));
        $display("register access test done");
        // source select, rails and guard over a table of control values
        foreach (ctab[j]) begin
            c = ctab[j];
            axw(OFS_CTRL, {24'h0, c});
            repeat (3) @(posedge aclk);
            chk(32'(guard_drive_en), 32'(c[1]));
            chk(32'(logic_out_high), 32'(c[0] ? c[5] : c[7]));
            chk(32'(logic_out_low_or_guard), 32'((c[0] ? c[4] : c[6]) & ~c[1]));
        end
        $display("logic output test done");
        // both polarities at both sides of mid-scale
        for (int i = 0; i < 4; i++) begin
            d = i[0] ? 32'h0080_0000 : 32'h007F_FFFF;
            axw(OFS_CTRL, {29'h0, i[1], 2'b00});
            axw(OFS_CONV_IN, d);
            axr(OFS_CONV_OUT);
            chk(v, i[1] ? d : d ^ 32'h0080_0000);
        end
        $display("polarity test done");
        axw(OFS_TX_DATA, 32'hA55A_0000);
        spsl_host_inst.stray(3);
        spsl_host_inst.xfer(8'h3C, rx, ok);
        chk(32'(rx), 32'h0000_00A5);
        chk(32'(ok), 32'h0000_0001);
        repeat (8) @(posedge aclk);
        chk(32'(serial_data_out_oe), 32'h0000_0000);
        axr(OFS_STATUS);
        chk({16'h0, v[15:8], 6'h0, v[1], 1'b0}, 32'h0000_3C02);
        // fourteen ones bytes fall short, fifteen enter command mode
        for (int i = 0; i < 2; i++) begin
            axw(OFS_STATUS, 32'h0000_0003);
            repeat (14 + i) spsl_host_inst.xfer(SYNC_ONES, rx, ok);
            spsl_host_inst.xfer(SYNC_FINAL, rx, ok);
            axr(OFS_STATUS);
            chk(32'(v[0]), 32'(i));
        end
        $display("serial link test done");
        report_and_stop();
    end
endmodule // test_spsl_top
